// *** pkg/nand_prot_regs.svh ***
// Register offsets, field positions, command bytes and timing counts
`ifndef NAND_PROT_REGS_SVH
`define NAND_PROT_REGS_SVH

// ****************************
// Register offsets
// ****************************
`define REG_CMD 8'h00
`define REG_ARG 8'h04
`define REG_SCR 8'h08
`define REG_STATUS 8'h0C

// ****************************
// Fields and operation codes
// ****************************
`define CMD_OP_MSB 2
`define ST_BUSY 0
`define ST_ERR 1
`define ST_OTP_DONE 2
`define ST_SCR_DONE 3
`define ST_RB_LSB 8
`define SCR_EN 0
`define SCR_OPT 1
`define OP_OTP_LOCK 3'h1
`define OP_SET_PROT 3'h2
`define OP_SCR_PGM 3'h3
`define OP_GET_FEAT 3'h4

// ****************************
// Flash command and feature bytes
// ****************************
`define NC_SET_FEAT 8'hEF
`define NC_GET_FEAT 8'hEE
`define NC_PROG 8'h80
`define NC_PROG_GO 8'h10
`define FA_OTP 8'h90
`define FA_PROT 8'hA0
`define FA_CONFIG 8'hB0
`define OTP_LOCK_P1 8'h03
`define OTP_EXIT_P1 8'h00
`define CFG_CONFIG_PROGRAM_ENABLE_P1 8'h01

// ****************************
// Timing, in ns and in 4 ns cycles
// ****************************
`define CLK_NS 4
`define WE_LOW_NS 12
`define WE_HIGH_NS 12
`define RE_LOW_NS 20
`define WB_NS 100
`define WW_NS 100
`define WE_LOW_CYC ((`WE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define WE_HIGH_CYC ((`WE_HIGH_NS + `CLK_NS - 1) / `CLK_NS)
`define RE_LOW_CYC ((`RE_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define WB_CYC ((`WB_NS + `CLK_NS - 1) / `CLK_NS)
`define WW_CYC ((`WW_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** pkg/nand_prot_pkg.sv ***
// Types shared by the protection controller and its cycle engine
package nand_prot_pkg;
  typedef enum logic [2:0] {
    K_CMD = 3'h0,
    K_ADDR = 3'h1,
    K_DATA = 3'h2,
    K_WAIT = 3'h3,
    K_READ = 3'h4,
    K_END = 3'h5
  } item_kind_e;

  typedef struct packed {
    item_kind_e kind;
    logic [7:0] data;
  } step_s;
endpackage

// *** pkg/nand_step_if.sv ***
// One bus cycle request from the sequencer to the pin engine
`timescale 1ns/1ps
`default_nettype none
interface nand_step_if;
  import nand_prot_pkg::*;
  logic req;
  logic sel;
  item_kind_e kind;
  logic [7:0] data;
  logic done;
  logic [7:0] rdata;
  modport seq(output req, output sel, output kind, output data, input done, input rdata);
  modport eng(input req, input sel, input kind, input data, output done, output rdata);
endinterface
`default_nettype wire

// *** logic/nand_cycle_engine.sv ***
// Pin engine: runs one command, address, data, read or ready-wait cycle
`timescale 1ns/1ps
`default_nettype none
`include "nand_prot_regs.svh"
module nand_cycle_engine
  import nand_prot_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  nand_step_if.eng step,
  input wire logic [7:0] i_io,
  input wire logic i_rb_n,
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_re_n,
  output logic [7:0] o_io,
  output logic o_io_oe
);
  typedef enum logic [4:0] {
    E_IDLE = 5'b00001,
    E_LOW = 5'b00010,
    E_HIGH = 5'b00100,
    E_TWB = 5'b01000,
    E_RB = 5'b10000
  } eng_state_e;

  eng_state_e state_q;
  logic [7:0] cnt_q;
  logic is_read_q;
  wire cnt_zero = (cnt_q == 8'h00);
  wire is_write = (step.kind == K_CMD) || (step.kind == K_ADDR) || (step.kind == K_DATA);

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= E_IDLE;
      cnt_q <= 8'h00;
      is_read_q <= 1'b0;
      o_ce_n <= 1'b1;
      o_cle <= 1'b0;
      o_ale <= 1'b0;
      o_we_n <= 1'b1;
      o_re_n <= 1'b1;
      o_io <= 8'h00;
      o_io_oe <= 1'b0;
      step.done <= 1'b0;
      step.rdata <= 8'h00;
    end else begin
      o_ce_n <= ~step.sel;
      step.done <= 1'b0;
      case (state_q)
        E_IDLE: begin
          if (step.req && is_write) begin
            o_cle <= (step.kind == K_CMD);
            o_ale <= (step.kind == K_ADDR);
            o_we_n <= 1'b0;
            o_io <= step.data;
            o_io_oe <= 1'b1;
            is_read_q <= 1'b0;
            cnt_q <= 8'(`WE_LOW_CYC - 1);
            state_q <= E_LOW;
          end else if (step.req && step.kind == K_READ) begin
            o_re_n <= 1'b0;
            is_read_q <= 1'b1;
            cnt_q <= 8'(`RE_LOW_CYC - 1);
            state_q <= E_LOW;
          end else if (step.req && step.kind == K_WAIT) begin
            cnt_q <= 8'(`WB_CYC - 1);
            state_q <= E_TWB;
          end
        end
        E_LOW: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_zero) begin
            o_we_n <= 1'b1;
            o_re_n <= 1'b1;
            if (is_read_q) begin
              step.rdata <= i_io;
            end
            cnt_q <= 8'(`WE_HIGH_CYC - 1);
            state_q <= E_HIGH;
          end
        end
        E_HIGH: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_zero) begin
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_io_oe <= 1'b0;
            step.done <= 1'b1;
            state_q <= E_IDLE;
          end
        end
        E_TWB: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_zero) begin
            state_q <= E_RB;
          end
        end
        E_RB: begin
          if (i_rb_n) begin
            step.done <= 1'b1;
            state_q <= E_IDLE;
          end
        end
        default: state_q <= E_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** logic/nand_prot_host.sv ***
// Host controller for flash OTP lock, block protection and scrambler setup
`timescale 1ns/1ps
`default_nettype none
`include "nand_prot_regs.svh"
module nand_prot_host
  import nand_prot_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic [7:0] i_io,
  input wire logic i_rb_n,
  output logic o_ce_n,
  output logic o_cle,
  output logic o_ale,
  output logic o_we_n,
  output logic o_re_n,
  output logic o_wp_n,
  output logic [7:0] o_io,
  output logic o_io_oe
);
  // ****************************
  // Command sequences
  // ****************************
  function automatic step_s mk(input item_kind_e k, input logic [7:0] d);
    step_s s;
    s.kind = k;
    s.data = d;
    return s;
  endfunction

  // Set-feature: command, feature address, P1, three zero bytes, ready wait
  function automatic step_s set_feat(input logic [4:0] i, input logic [7:0] fa,
                                     input logic [7:0] p1);
    step_s s;
    s = mk(K_DATA, 8'h00);
    if (i == 5'd0) s = mk(K_CMD, `NC_SET_FEAT);
    else if (i == 5'd1) s = mk(K_ADDR, fa);
    else if (i == 5'd2) s = mk(K_DATA, p1);
    else if (i == 5'd6) s = mk(K_WAIT, 8'h00);
    return s;
  endfunction

  function automatic step_s seq_step(input logic [2:0] op, input logic [4:0] i,
                                     input logic [7:0] arg, input logic [1:0] scr);
    step_s s;
    s = mk(K_END, 8'h00);
    case (op)
      `OP_OTP_LOCK: begin
        if (i < 5'd7) s = set_feat(i, `FA_OTP, `OTP_LOCK_P1);
        else if (i == 5'd7) s = mk(K_CMD, `NC_PROG);
        else if (i < 5'd13) s = mk(K_ADDR, 8'h00);
        else if (i == 5'd13) s = mk(K_CMD, `NC_PROG_GO);
        else if (i == 5'd14) s = mk(K_WAIT, 8'h00);
        else if (i < 5'd22) s = set_feat(i - 5'd15, `FA_OTP, `OTP_EXIT_P1);
      end
      `OP_SET_PROT: begin
        if (i < 5'd7) s = set_feat(i, `FA_PROT, arg);
      end
      `OP_SCR_PGM: begin
        if (i < 5'd7) s = set_feat(i, `FA_CONFIG, `CFG_CONFIG_PROGRAM_ENABLE_P1);
        else if (i < 5'd14) s = set_feat(i - 5'd7, `FA_CONFIG, {5'h00, scr, 1'b1});
        else if (i < 5'd21) s = set_feat(i - 5'd14, `FA_CONFIG, 8'h00);
        else if (i == 5'd21) s = mk(K_CMD, `NC_GET_FEAT);
        else if (i == 5'd22) s = mk(K_ADDR, `FA_CONFIG);
        else if (i == 5'd23) s = mk(K_WAIT, 8'h00);
        else if (i == 5'd24) s = mk(K_READ, 8'h00);
      end
      `OP_GET_FEAT: begin
        if (i == 5'd0) s = mk(K_CMD, `NC_GET_FEAT);
        else if (i == 5'd1) s = mk(K_ADDR, arg);
        else if (i == 5'd2) s = mk(K_WAIT, 8'h00);
        else if (i == 5'd3) s = mk(K_READ, 8'h00);
      end
      default: s = mk(K_END, 8'h00);
    endcase
    return s;
  endfunction

  // ****************************
  // Bus slave
  // ****************************
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WPSET = 4'b0010,
    S_ISSUE = 4'b0100,
    S_WAIT = 4'b1000
  } seq_state_e;

  seq_state_e state_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [2:0] op_q;
  logic [4:0] idx_q;
  logic [7:0] arg_q;
  logic [1:0] scr_q;
  logic [7:0] cnt_q;
  logic err_q;
  logic otp_done_q;
  logic scr_done_q;
  logic [7:0] rb_q;
  logic req_q;
  logic sel_q;
  item_kind_e kind_q;
  logic [7:0] data_q;

  nand_step_if step ();

  wire addr_ok = i_hsel && i_htrans[1] && i_hready;
  wire [7:0] a_off = i_haddr[7:0];
  wire wr_cmd = wr_pend_q && (wr_addr_q == `REG_CMD);
  wire wr_arg = wr_pend_q && (wr_addr_q == `REG_ARG);
  wire wr_scr = wr_pend_q && (wr_addr_q == `REG_SCR);
  wire wr_st = wr_pend_q && (wr_addr_q == `REG_STATUS);
  wire [2:0] new_op = i_hwdata[`CMD_OP_MSB:0];
  wire busy = (state_q != S_IDLE);
  wire op_known = (new_op >= `OP_OTP_LOCK) && (new_op <= `OP_GET_FEAT);
  // Lock and scrambler program are one-shot; a repeat is refused
  wire op_refused = ((new_op == `OP_SCR_PGM) && scr_done_q) ||
                    ((new_op == `OP_OTP_LOCK) && otp_done_q);
  wire start_ok = wr_cmd && !busy && op_known && !op_refused;
  wire start_bad = wr_cmd && (busy || !op_known || op_refused);
  wire step_s cur = seq_step(op_q, idx_q, arg_q, scr_q);
  wire [31:0] status_w = {16'h0000, rb_q, 4'h0, scr_done_q, otp_done_q, err_q, busy};
  wire [31:0] rd_mux = (a_off == `REG_CMD) ? {29'h0, op_q} :
                       (a_off == `REG_ARG) ? {24'h0, arg_q} :
                       (a_off == `REG_SCR) ? {30'h0, scr_q} :
                       (a_off == `REG_STATUS) ? status_w : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hrdata <= 32'h0000_0000;
      o_hresp <= 1'b0;
      arg_q <= 8'h00;
      scr_q <= 2'h0;
      err_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && i_hwrite;
      wr_addr_q <= a_off;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      if (addr_ok && !i_hwrite) begin
        o_hrdata <= rd_mux;
      end
      if (wr_arg) begin
        arg_q <= i_hwdata[7:0];
      end
      if (wr_scr) begin
        scr_q <= {i_hwdata[`SCR_OPT], i_hwdata[`SCR_EN]};
      end
      if (start_bad) begin
        err_q <= 1'b1;
      end else if (wr_st && i_hwdata[`ST_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end

  // ****************************
  // Sequencer
  // ****************************
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= S_IDLE;
      op_q <= 3'h0;
      idx_q <= 5'h00;
      cnt_q <= 8'h00;
      otp_done_q <= 1'b0;
      scr_done_q <= 1'b0;
      rb_q <= 8'h00;
      req_q <= 1'b0;
      sel_q <= 1'b0;
      kind_q <= K_END;
      data_q <= 8'h00;
      o_wp_n <= 1'b0;
    end else begin
      req_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (start_ok) begin
            op_q <= new_op;
            idx_q <= 5'h00;
            o_wp_n <= 1'b1;
            cnt_q <= 8'(`WW_CYC - 1);
            state_q <= S_WPSET;
          end
        end
        S_WPSET: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h00) begin
            sel_q <= 1'b1;
            state_q <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (cur.kind == K_END) begin
            sel_q <= 1'b0;
            otp_done_q <= otp_done_q || (op_q == `OP_OTP_LOCK);
            scr_done_q <= scr_done_q || (op_q == `OP_SCR_PGM);
            state_q <= S_IDLE;
          end else begin
            req_q <= 1'b1;
            kind_q <= cur.kind;
            data_q <= cur.data;
            state_q <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (step.done) begin
            if (kind_q == K_READ) begin
              rb_q <= step.rdata;
            end
            idx_q <= idx_q + 5'h01;
            state_q <= S_ISSUE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign step.req = req_q;
  assign step.sel = sel_q;
  assign step.kind = kind_q;
  assign step.data = data_q;

  nand_cycle_engine u_engine (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .step(step.eng),
    .i_io(i_io),
    .i_rb_n(i_rb_n),
    .o_ce_n(o_ce_n),
    .o_cle(o_cle),
    .o_ale(o_ale),
    .o_we_n(o_we_n),
    .o_re_n(o_re_n),
    .o_io(o_io),
    .o_io_oe(o_io_oe)
  );

  // ****************************
  // Checks
  // ****************************
  a_wp_before_feat: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    req_q && kind_q == K_CMD && data_q == `NC_SET_FEAT |-> o_wp_n && !o_ce_n)
    else $error("set-feature issued with write-protect low");
  a_otp_lock_p1: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    req_q && op_q == `OP_OTP_LOCK && idx_q == 5'd2 |-> kind_q == K_DATA && data_q == 8'h03)
    else $error("OTP lock P1 is not 03h");
  a_lock_last_addr: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    req_q && op_q == `OP_OTP_LOCK && idx_q == 5'd13 |->
      data_q == `NC_PROG_GO && $past(kind_q == K_ADDR && data_q == 8'h00, 2))
    else $error("lock confirm not preceded by 00h address");
  a_otp_exit_p1: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    req_q && op_q == `OP_OTP_LOCK && idx_q == 5'd17 |-> kind_q == K_DATA && data_q == 8'h00)
    else $error("OTP mode not left with P1 00h");
  a_prot_byte: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    req_q && op_q == `OP_SET_PROT && idx_q == 5'd2 |-> data_q == arg_q && kind_q == K_DATA)
    else $error("protection byte differs from argument");
  a_config_program_enable_order: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    req_q && op_q == `OP_SCR_PGM && (idx_q == 5'd2 || idx_q == 5'd16) |->
      data_q == ((idx_q == 5'd2) ? 8'h01 : 8'h00))
    else $error("program enable not set before or cleared after");
  a_scr_once: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    scr_done_q && wr_cmd && new_op == `OP_SCR_PGM |=> err_q && !(state_q == S_WPSET))
    else $error("second scrambler program not refused");
  a_readback: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    state_q == S_WAIT && step.done && kind_q == K_READ |=> rb_q == $past(step.rdata))
    else $error("read-back byte not kept");
endmodule
`default_nettype wire

// *** bench/nand_dev_model.sv ***
// Behavioural flash device answering the protection controller
`timescale 1ns/1ps
`default_nettype none
`include "nand_prot_regs.svh"
module nand_dev_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_strap,
  input wire logic [7:0] i_busy_cyc,
  input wire logic i_ce_n,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic i_wp_n,
  input wire logic [7:0] i_io,
  output logic o_rb_n,
  output logic [7:0] o_io,
  output logic o_io_oe,
  output var logic o_otp_locked
);
  logic [7:0] cmd_q, fa_q, p1_q, prot_q, busy_q, otp_mode_q;
  logic [2:0] idx_q;
  logic [1:0] scr_q;
  logic we_q, solid_q, config_program_enable_q, scr_done_q;
  wire logic strobe;
  assign strobe = i_we_n && !we_q && !i_ce_n;
  assign o_rb_n = (busy_q == 8'h00);
  assign o_io_oe = !i_ce_n && !i_re_n;
  // Status reads answer before any feature readback
  assign o_io = (cmd_q == 8'h70) ? {i_wp_n, 7'h00} :
                (cmd_q == 8'h7A && i_strap) ? prot_q :
                (fa_q == `FA_PROT) ? prot_q :
                (fa_q == `FA_CONFIG) ? {5'h00, scr_q, config_program_enable_q} : otp_mode_q;
  // Nonvolatile state survives reset
  initial begin
    o_otp_locked = 1'b0;
    scr_q = 2'h0;
    scr_done_q = 1'b0;
  end
  always @(posedge i_clk) begin
    we_q <= i_we_n;
    if (busy_q != 8'h00) begin
      busy_q <= busy_q - 8'h01;
    end
    if (!i_reset_n) begin
      prot_q <= i_strap ? 8'h38 : 8'h00;
      solid_q <= 1'b0;
      config_program_enable_q <= 1'b0;
      otp_mode_q <= 8'h00;
      busy_q <= 8'h00;
      cmd_q <= 8'h00;
      fa_q <= 8'h00;
      idx_q <= 3'h0;
    end else if (strobe && i_cle) begin
      cmd_q <= i_io;
      idx_q <= 3'h0;
      if (i_io == `NC_PROG_GO) begin
        // Busy also covers a refused program on a locked block
        busy_q <= i_busy_cyc;
        if (otp_mode_q == `OTP_LOCK_P1) begin
          o_otp_locked <= 1'b1;
        end
      end
    end else if (strobe && i_ale) begin
      if (cmd_q != `NC_PROG) begin
        fa_q <= i_io;
      end
      if (cmd_q == `NC_GET_FEAT) begin
        busy_q <= i_busy_cyc;
      end
    end else if (strobe && cmd_q == `NC_SET_FEAT) begin
      idx_q <= idx_q + 3'h1;
      if (idx_q == 3'h0) begin
        p1_q <= i_io;
      end
      if (idx_q == 3'h3) begin
        busy_q <= i_busy_cyc;
        if (fa_q == `FA_OTP) begin
          otp_mode_q <= p1_q;
        end
        if (fa_q == `FA_PROT && i_strap && i_wp_n && !solid_q) begin
          prot_q <= p1_q;
          solid_q <= p1_q[0];
        end
        if (fa_q == `FA_CONFIG) begin
          config_program_enable_q <= p1_q[0];
          if (p1_q[0] && config_program_enable_q && !scr_done_q) begin
            scr_q <= p1_q[2:1];
            scr_done_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/nand_prot_host_bench.sv ***
// Self-checking bench for the flash protection controller
`timescale 1ns/1ps
`default_nettype none
`include "nand_prot_regs.svh"
module nand_prot_host_bench;
  logic i_clk, i_reset_n, hsel, hwrite, rd_pend;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rng_q, e_w, m_w;
  logic [7:0] busy_cyc, io_hold, v;
  wire logic hready, hresp, dut_oe, dev_oe, ce_n, cle, ale, we_n, re_n, wp_n, rb_n, locked;
  wire logic [31:0] hrdata;
  wire logic [7:0] dut_io, dev_io, io_w;
  int failures, cmp_count, cycles;
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  assign io_w = dut_oe ? dut_io : dev_oe ? dev_io : io_hold;
  nand_prot_host i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(hresp), .i_io(io_w), .i_rb_n(rb_n),
    .o_ce_n(ce_n), .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_re_n(re_n), .o_wp_n(wp_n),
    .o_io(dut_io), .o_io_oe(dut_oe));
  nand_dev_model i_dev (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_strap(1'b1),
    .i_busy_cyc(busy_cyc), .i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n),
    .i_re_n(re_n), .i_wp_n(wp_n), .i_io(io_w), .o_rb_n(rb_n), .o_io(dev_io),
    .o_io_oe(dev_oe), .o_otp_locked(locked));
  // ****************************
  // Helpers
  // ****************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    ahb(1'b0, a, 32'h0);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      rd_check(`REG_STATUS, 32'h0, 32'h0);
      n++;
    end while (hrdata[`ST_BUSY] !== 1'b0 && n < 3000);
    if (hrdata[`ST_BUSY] !== 1'b0) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic op(input logic [2:0] code, input logic [7:0] arg);
    rng_q = xs(rng_q);
    busy_cyc <= 8'h02 + {2'h0, rng_q[5:0]};
    ahb(1'b1, `REG_ARG, {24'h000000, arg});
    ahb(1'b1, `REG_CMD, {29'h0, code});
    rd_check(`REG_STATUS, 32'h1, 32'h1);
    wait_idle();
  endtask
  // ****************************
  // Clock, watcher and timeout
  // ****************************
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    io_hold <= ~io_w;
    cycles <= cycles + 1;
    if (cle && !we_n && io_w == `NC_SET_FEAT) begin
      check_word("wp_n", 32'h1, {31'h0, wp_n});
    end
    if (rd_pend && hready === 1'b1) begin
      e_w = exp_q.pop_front();
      m_w = mask_q.pop_front();
      if (m_w != 32'h0) begin
        check_word("ahb read", e_w, hrdata & m_w);
      end
      check_word("hresp", 32'h0, {31'h0, hresp});
    end
    rd_pend <= (rd_pend && hready !== 1'b1) || (hsel && htrans[1] && !hwrite && hready);
    if (cycles == 80000) begin
      failures++;
      end_of_test();
    end
  end
  // ****************************
  // Scenarios
  // ****************************
  initial begin
    i_reset_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    busy_cyc = 8'h10;
    io_hold = 8'hA5;
    rd_pend = 1'b0;
    rng_q = 32'd30;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    rd_check(`REG_STATUS, 32'h0, 32'hFF0F);
    rd_check(8'h10, 32'h0, 32'hFFFFFFFF);
    op(3'h4, `FA_PROT);
    rd_check(`REG_STATUS, 32'h3800, 32'hFF03);
    for (int i = 0; i < 6; i++) begin
      rng_q = xs(rng_q);
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h32 : (i == 2) ? 8'h36 : rng_q[7:0] & 8'h3E;
      op(3'h2, v);
      op(3'h4, `FA_PROT);
      rd_check(`REG_STATUS, {16'h0, v, 8'h00}, 32'hFF03);
    end
    op(3'h2, 8'h19);
    op(3'h2, 8'h00);
    op(3'h4, `FA_PROT);
    rd_check(`REG_STATUS, 32'h1900, 32'hFF03);
    ahb(1'b1, `REG_CMD, 32'h1);
    ahb(1'b1, `REG_CMD, 32'h2);
    wait_idle();
    rd_check(`REG_STATUS, 32'h6, 32'h7);
    check_word("otp lock", 32'h1, {31'h0, locked});
    ahb(1'b1, `REG_STATUS, 32'h2);
    op(3'h4, `FA_OTP);
    rd_check(`REG_STATUS, 32'h0, 32'hFF03);
    ahb(1'b1, `REG_CMD, 32'h1);
    rd_check(`REG_STATUS, 32'h2, 32'h3);
    ahb(1'b1, `REG_STATUS, 32'h2);
    ahb(1'b1, `REG_CMD, 32'h7);
    rd_check(`REG_STATUS, 32'h2, 32'h3);
    ahb(1'b1, `REG_STATUS, 32'h2);
    rng_q = xs(rng_q);
    v = {6'h00, rng_q[0], 1'b1};
    ahb(1'b1, `REG_SCR, {24'h000000, v});
    op(3'h3, 8'h00);
    rd_check(`REG_STATUS, {16'h0, 5'h00, v[1:0], 1'b0, 8'h08}, 32'hFF0B);
    ahb(1'b1, `REG_SCR, {30'h0, ~v[1], 1'b1});
    ahb(1'b1, `REG_CMD, 32'h3);
    rd_check(`REG_STATUS, 32'h2, 32'h3);
    ahb(1'b1, `REG_STATUS, 32'h2);
    op(3'h4, `FA_CONFIG);
    rd_check(`REG_STATUS, {16'h0, 5'h00, v[1:0], 1'b0, 8'h00}, 32'hFF03);
    rd_check(`REG_ARG, {24'h000000, `FA_CONFIG}, 32'hFFFFFFFF);
    rd_check(`REG_CMD, 32'h4, 32'hFFFFFFFF);
    rd_check(`REG_SCR, {30'h0, ~v[1], 1'b1}, 32'hFFFFFFFF);
    i_reset_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    op(3'h4, `FA_CONFIG);
    rd_check(`REG_STATUS, {16'h0, 5'h00, v[1:0], 1'b0, 8'h00}, 32'hFF03);
    op(3'h4, `FA_PROT);
    rd_check(`REG_STATUS, 32'h3800, 32'hFF03);
    repeat (4) @(posedge i_clk);
    check_word("queue", 32'h0, 32'(exp_q.size()));
    end_of_test();
  end
endmodule
`default_nettype wire
